// >>> core/flash_program_erase_control.sv
/*
  Register-level program/erase/verify control for a two-region on-chip flash array, with
  erase-block selection and the RAM overlay control. Software reaches the registers over APB.
  Assumes hw_protect_pin is an asynchronous pin; standby, flash_disabled, rom_disabled and
  op_failed come from logic on clk.

*/
`timescale 1ns/10ps
`include "flash_pe_regs.svh"
`default_nettype none

module flash_program_erase_control
  import flash_pe_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hw_protect_pin,
  input wire logic standby,
  input wire logic flash_disabled,
  input wire logic rom_disabled,
  input wire logic op_failed,
  input wire logic [17:0] probe_addr,
  output logic erase_setup_lo,
  output logic prog_setup_lo,
  output logic erase_verify_lo,
  output logic prog_verify_lo,
  output logic erase_go_lo,
  output logic prog_go_lo,
  output logic erase_setup_hi,
  output logic prog_setup_hi,
  output logic erase_verify_hi,
  output logic prog_verify_hi,
  output logic erase_go_hi,
  output logic prog_go_hi,
  output logic [11:0] erase_allow,
  output logic pe_protected,
  output logic overlay_active,
  output logic [11:0] overlay_block,
  output logic [11:0] probe_block
);

  logic rst_meta;
  logic rst_sync;
  logic pin_meta;
  logic pin_sync;
  logic write_pin_status;
  logic soft_write_enable;
  logic flash_error_flag;
  byte_t ctrl_lo;
  byte_t ctrl_hi;
  byte_t eblk_lo;
  byte_t eblk_hi;
  logic overlay_select;
  logic [1:0] overlay_area;
  logic wr;
  logic rd;
  logic known;
  logic en;
  logic multi_blk;
  logic clear_ctl;
  blocks_t blocks;
  byte_t wbyte;
  logic [31:0] next_prdata;

  // One-hot block select for an 18-bit flash address
  function automatic blocks_t decode_block(input flash_addr_t a);
    blocks_t onehot;
    onehot = '0;
    if (a >= `BLK1K_BASE)
      onehot[4'(8 + 32'(a[11:10]))] = 1'b1;
    else if (a[17:`BLK32_SHIFT] == 3'h7)
      onehot[7] = 1'b1;
    else
      onehot[4'(a[17:`BLK32_SHIFT])] = 1'b1;
    return onehot;
  endfunction : decode_block

  function automatic blocks_t area_block(input logic [1:0] area);
    blocks_t onehot;
    onehot = '0;
    onehot[4'(8 + 32'(area))] = 1'b1;
    return onehot;
  endfunction : area_block

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // Protect pin is asynchronous; reset value assumes protected until sampled
  always_ff @(posedge clk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
    end
    else
    begin
      pin_meta <= hw_protect_pin;
      pin_sync <= pin_meta;
    end
  end

  assign write_pin_status = ~pin_sync;
  assign blocks = {eblk_hi, eblk_lo[3:0]};
  assign multi_blk = (blocks & (blocks - 12'h001)) != 12'h000;
  assign en = write_pin_status & soft_write_enable;
  assign clear_ctl = standby | ~en;
  assign wr = psel & penable & pwrite;
  assign rd = psel & ~pwrite & ~penable;
  assign wbyte = pwdata[7:0];
  assign known = (paddr == `OFF_CTRL_LOWER) || (paddr == `OFF_CTRL_UPPER) || (paddr == `OFF_EBLK_LOW)
    || (paddr == `OFF_EBLK_HIGH) || (paddr == `OFF_OVERLAY) || (paddr == `OFF_CONTROL);

  // Zero-wait slave: pready rises in the access phase, one cycle after setup
  always_ff @(posedge clk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~known;
    end
  end

  // Lower control register, written only via the gates below
  always_ff @(posedge clk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      ctrl_lo <= `RST_CTRL;
    end
    else if (standby || !write_pin_status)
    begin
      ctrl_lo <= `RST_CTRL;
    end
    else if (wr && pready && paddr == `OFF_CTRL_LOWER && !flash_disabled)
    begin
      ctrl_lo[`BIT_SOFT_WE] <= wbyte[`BIT_SOFT_WE];
      if (soft_write_enable)
      begin
        if (!multi_blk || !wbyte[`BIT_ERASE_SETUP])
          ctrl_lo[`BIT_ERASE_SETUP] <= wbyte[`BIT_ERASE_SETUP];
        ctrl_lo[`BIT_PROG_SETUP] <= wbyte[`BIT_PROG_SETUP];
        ctrl_lo[`BIT_ERASE_VERIFY] <= wbyte[`BIT_ERASE_VERIFY];
        ctrl_lo[`BIT_PROG_VERIFY] <= wbyte[`BIT_PROG_VERIFY];
        if (!wbyte[`BIT_ERASE_GO] || (ctrl_lo[`BIT_ERASE_SETUP] && !multi_blk && !pe_block_now()))
          ctrl_lo[`BIT_ERASE_GO] <= wbyte[`BIT_ERASE_GO];
        if (!wbyte[`BIT_PROG_GO] || (ctrl_lo[`BIT_PROG_SETUP] && !pe_block_now()))
          ctrl_lo[`BIT_PROG_GO] <= wbyte[`BIT_PROG_GO];
      end
    end
    else if (!soft_write_enable)
    begin
      ctrl_lo[5:0] <= 6'h00;
    end
  end

  assign soft_write_enable = ctrl_lo[`BIT_SOFT_WE];

  // Error and overlay protection blocks any new program or erase start
  function automatic logic pe_block_now();
    return flash_error_flag | (overlay_select & ~rom_disabled);
  endfunction : pe_block_now

  always_ff @(posedge clk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      ctrl_hi <= `RST_CTRL;
    end
    else if (clear_ctl)
    begin
      ctrl_hi <= `RST_CTRL;
    end
    else if (wr && pready && paddr == `OFF_CTRL_UPPER && !flash_disabled)
    begin
      if (!multi_blk || !wbyte[`BIT_ERASE_SETUP])
        ctrl_hi[`BIT_ERASE_SETUP] <= wbyte[`BIT_ERASE_SETUP];
      ctrl_hi[`BIT_PROG_SETUP] <= wbyte[`BIT_PROG_SETUP];
      ctrl_hi[`BIT_ERASE_VERIFY] <= wbyte[`BIT_ERASE_VERIFY];
      ctrl_hi[`BIT_PROG_VERIFY] <= wbyte[`BIT_PROG_VERIFY];
      if (!wbyte[`BIT_ERASE_GO] || (ctrl_hi[`BIT_ERASE_SETUP] && !multi_blk && !pe_block_now()))
        ctrl_hi[`BIT_ERASE_GO] <= wbyte[`BIT_ERASE_GO];
      if (!wbyte[`BIT_PROG_GO] || (ctrl_hi[`BIT_PROG_SETUP] && !pe_block_now()))
        ctrl_hi[`BIT_PROG_GO] <= wbyte[`BIT_PROG_GO];
    end
  end

  // Failure report wins over nothing: only reset clears the flag
  always_ff @(posedge clk or negedge rst_sync)
  begin
    if (!rst_sync)
      flash_error_flag <= 1'b0;
    else if (op_failed)
      flash_error_flag <= 1'b1;
  end

  always_ff @(posedge clk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      eblk_lo <= `RST_EBLK;
      eblk_hi <= `RST_EBLK;
    end
    else if (clear_ctl)
    begin
      eblk_lo <= `RST_EBLK;
      eblk_hi <= `RST_EBLK;
    end
    else if (wr && pready && !flash_disabled)
    begin
      if (paddr == `OFF_EBLK_LOW)
        eblk_lo <= wbyte & `MASK_EBLK_LOW;
      if (paddr == `OFF_EBLK_HIGH)
        eblk_hi <= wbyte;
    end
  end

  // Standby does not touch the overlay register
  always_ff @(posedge clk or negedge rst_sync)
  begin
    if (!rst_sync)
      {overlay_select, overlay_area} <= `RST_OVERLAY;
    else if (wr && pready && paddr == `OFF_OVERLAY)
      {overlay_select, overlay_area} <= pwdata[2:0];
  end

  always_comb
  begin
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      `OFF_CTRL_LOWER: next_prdata[7:0] = flash_disabled ? 8'h80 : {write_pin_status, ctrl_lo[6:0]};
      `OFF_CTRL_UPPER: next_prdata[7:0] = flash_disabled ? 8'h00
        : {flash_error_flag, 1'b0, ctrl_hi[5:0]};
      `OFF_EBLK_LOW: next_prdata[7:0] = flash_disabled ? 8'h00 : eblk_lo;
      `OFF_EBLK_HIGH: next_prdata[7:0] = flash_disabled ? 8'h00 : eblk_hi;
      `OFF_OVERLAY: next_prdata[2:0] = {overlay_select, overlay_area};
      `OFF_CONTROL: next_prdata[3:0] = {rom_disabled, flash_disabled, standby, pin_sync};
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync)
  begin
    if (!rst_sync)
      prdata <= 32'h0000_0000;
    else if (rd)
      prdata <= next_prdata;
  end

  // Mode outputs are registered copies so the array sees clean levels
  always_ff @(posedge clk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      {erase_setup_lo, prog_setup_lo, erase_verify_lo, prog_verify_lo, erase_go_lo, prog_go_lo} <= 6'h00;
      {erase_setup_hi, prog_setup_hi, erase_verify_hi, prog_verify_hi, erase_go_hi, prog_go_hi} <= 6'h00;
      erase_allow <= 12'h000;
      pe_protected <= 1'b1;
      overlay_active <= 1'b0;
      overlay_block <= 12'h000;
      probe_block <= 12'h000;
    end
    else
    begin
      {erase_setup_lo, prog_setup_lo, erase_verify_lo, prog_verify_lo, erase_go_lo, prog_go_lo} <= ctrl_lo[5:0];
      {erase_setup_hi, prog_setup_hi, erase_verify_hi, prog_verify_hi, erase_go_hi, prog_go_hi} <= ctrl_hi[5:0];
      erase_allow <= pe_block_now() ? 12'h000 : blocks;
      pe_protected <= pe_block_now() | ~write_pin_status;
      overlay_active <= overlay_select & ~rom_disabled;
      overlay_block <= (overlay_select && !rom_disabled) ? area_block(overlay_area) : 12'h000;
      probe_block <= decode_block(probe_addr);
    end
  end

  // Assertions
  // Failure report: flag first, then the registered protect output one cycle later
  sequence flag_then_protect;
    flash_error_flag ##1 (flash_error_flag && pe_protected);
  endsequence

  a_lower_setup_gate: assert property (@(posedge clk) disable iff (!rst_sync)
    $rose(ctrl_lo[`BIT_ERASE_SETUP]) |-> $past(en) && !$past(multi_blk))
    else $error("lower erase setup set without enable");
  a_lower_psetup_gate: assert property (@(posedge clk) disable iff (!rst_sync)
    $rose(ctrl_lo[`BIT_PROG_SETUP]) |-> $past(en))
    else $error("lower program setup set without enable");
  a_lower_everify: assert property (@(posedge clk) disable iff (!rst_sync)
    $rose(ctrl_lo[`BIT_ERASE_VERIFY]) |-> $past(en))
    else $error("lower erase verify set without enable");
  a_lower_pverify: assert property (@(posedge clk) disable iff (!rst_sync)
    $rose(ctrl_lo[`BIT_PROG_VERIFY]) |-> $past(en))
    else $error("lower program verify set without enable");
  a_lower_erase_go: assert property (@(posedge clk) disable iff (!rst_sync)
    $rose(ctrl_lo[`BIT_ERASE_GO]) |-> $past(ctrl_lo[`BIT_ERASE_SETUP]) && $past(en))
    else $error("lower erase go without setup");
  a_lower_prog_go: assert property (@(posedge clk) disable iff (!rst_sync)
    $rose(ctrl_lo[`BIT_PROG_GO]) |-> $past(ctrl_lo[`BIT_PROG_SETUP]) && $past(en))
    else $error("lower program go without setup");
  a_lower_pin_clear: assert property (@(posedge clk) disable iff (!rst_sync)
    !write_pin_status |=> ctrl_lo == 8'h00)
    else $error("lower register not cleared while pin protects");
  a_upper_setup_gate: assert property (@(posedge clk) disable iff (!rst_sync)
    $rose(ctrl_hi[`BIT_PROG_SETUP]) |-> $past(en))
    else $error("upper setup set without enable");
  a_upper_esetup_gate: assert property (@(posedge clk) disable iff (!rst_sync)
    $rose(ctrl_hi[`BIT_ERASE_SETUP]) |-> $past(en) && !$past(multi_blk))
    else $error("upper erase setup set without enable or with several blocks");
  a_upper_everify: assert property (@(posedge clk) disable iff (!rst_sync)
    $rose(ctrl_hi[`BIT_ERASE_VERIFY]) |-> $past(en))
    else $error("upper erase verify set without enable");
  a_upper_erase_go: assert property (@(posedge clk) disable iff (!rst_sync)
    $rose(ctrl_hi[`BIT_ERASE_GO]) |-> $past(ctrl_hi[`BIT_ERASE_SETUP]) && !$past(multi_blk))
    else $error("upper erase go without setup");
  a_upper_prog_go: assert property (@(posedge clk) disable iff (!rst_sync)
    $rose(ctrl_hi[`BIT_PROG_GO]) |-> $past(ctrl_hi[`BIT_PROG_SETUP]))
    else $error("upper program go without setup");
  a_upper_clears: assert property (@(posedge clk) disable iff (!rst_sync)
    clear_ctl |=> ctrl_hi == 8'h00 && eblk_lo == 8'h00 && eblk_hi == 8'h00)
    else $error("upper or block register not cleared");
  a_flag_kept: assert property (@(posedge clk) disable iff (!rst_sync)
    flash_error_flag |=> flash_error_flag)
    else $error("error flag cleared without reset");
  a_error_sticky: assert property (@(posedge clk) disable iff (!rst_sync)
    op_failed |=> flag_then_protect)
    else $error("error flag not held");
  a_overlay_protect: assert property (@(posedge clk) disable iff (!rst_sync)
    overlay_select && !rom_disabled |=> erase_allow == 12'h000)
    else $error("overlay select did not protect");

endmodule : flash_program_erase_control

`default_nettype wire

// >>> core/flash_pe_regs.svh
/*
  Register offsets, field positions, reset values and address-range constants of the flash
  program/erase control block.
  Assumes inclusion by bare name from the design module and the testbench.
*/
`ifndef FLASH_PE_REGS_SVH
`define FLASH_PE_REGS_SVH

`define OFF_CTRL_LOWER 12'h000
`define OFF_CTRL_UPPER 12'h004
`define OFF_EBLK_LOW 12'h008
`define OFF_EBLK_HIGH 12'h00C
`define OFF_OVERLAY 12'h010
`define OFF_CONTROL 12'h014

`define BIT_PROG_GO 0
`define BIT_ERASE_GO 1
`define BIT_PROG_VERIFY 2
`define BIT_ERASE_VERIFY 3
`define BIT_PROG_SETUP 4
`define BIT_ERASE_SETUP 5
`define BIT_SOFT_WE 6
`define BIT_WRITE_PIN 7
`define BIT_ERROR_FLAG 7
`define BIT_OVERLAY_SELECT 2

`define RST_CTRL 8'h00
`define RST_EBLK 8'h00
`define RST_OVERLAY 3'h0
`define MASK_EBLK_LOW 8'h0F
`define MASK_UPPER_MODES 8'h3F

`define BLK32_SHIFT 15
`define BLK1K_BASE 18'h3F000
`define BLK1K_SHIFT 10

`endif

// >>> core/flash_pe_pkg.sv
/*
  Types shared by the flash program/erase control block.
  Assumes the register header is on the include path.
*/
package flash_pe_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [11:0] blocks_t;
  typedef logic [17:0] flash_addr_t;
  typedef enum logic [1:0] {REGION_NONE, REGION_LOWER, REGION_UPPER} region_t;
endpackage : flash_pe_pkg

// >>> verification/test_flash_program_erase_control.sv
/*
  Self-checking testbench for the flash program/erase control block: APB register accesses,
  gating of setup/verify/go bits, erase-block selection, overlay, error flag, standby, pin protect
  and block decode.
  Assumes the register header and the package are compiled and on the include path.
*/
`timescale 1ns/10ps
`include "flash_pe_regs.svh"
`default_nettype none

module test_flash_program_erase_control import flash_pe_pkg::*;;
  localparam logic [11:0] a_lo = `OFF_CTRL_LOWER;
  localparam logic [11:0] a_up = `OFF_CTRL_UPPER;
  localparam logic [11:0] a_el = `OFF_EBLK_LOW;
  localparam logic [11:0] a_eh = `OFF_EBLK_HIGH;
  localparam logic [11:0] a_ov = `OFF_OVERLAY;
  localparam logic [11:0] a_st = `OFF_CONTROL;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic hw_protect_pin = 1'b0;
  logic standby = 1'b0;
  logic flash_disabled = 1'b0;
  logic rom_disabled = 1'b0;
  logic op_failed = 1'b0;
  logic [17:0] probe_addr = 18'h00000;
  logic erase_setup_lo, prog_setup_lo, erase_verify_lo, prog_verify_lo, erase_go_lo, prog_go_lo;
  logic erase_setup_hi, prog_setup_hi, erase_verify_hi, prog_verify_hi, erase_go_hi, prog_go_hi;
  logic [11:0] erase_allow, overlay_block, probe_block;
  logic pe_protected, overlay_active;
  logic [5:0] lo_modes, hi_modes;
  logic [31:0] rdat;
  logic rerr;
  int bad_count = 0;
  int checked = 0;
  logic [17:0] pa [7] = '{18'h00000, 18'h37FFF, 18'h38000, 18'h3EFFF, 18'h3F000, 18'h3F7FF, 18'h3FC00};
  int pb [7] = '{0, 6, 7, 7, 8, 9, 11};

  // Mode outputs lined up with register bits 5..0 so one compare covers all six
  assign lo_modes = {erase_setup_lo, prog_setup_lo, erase_verify_lo, prog_verify_lo, erase_go_lo, prog_go_lo};
  assign hi_modes = {erase_setup_hi, prog_setup_hi, erase_verify_hi, prog_verify_hi, erase_go_hi, prog_go_hi};

  always #5 clk = ~clk;

  flash_program_erase_control uut (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .hw_protect_pin(hw_protect_pin),
    .standby(standby), .flash_disabled(flash_disabled), .rom_disabled(rom_disabled), .op_failed(op_failed),
    .probe_addr(probe_addr), .erase_setup_lo(erase_setup_lo), .prog_setup_lo(prog_setup_lo),
    .erase_verify_lo(erase_verify_lo), .prog_verify_lo(prog_verify_lo), .erase_go_lo(erase_go_lo),
    .prog_go_lo(prog_go_lo), .erase_setup_hi(erase_setup_hi), .prog_setup_hi(prog_setup_hi),
    .erase_verify_hi(erase_verify_hi), .prog_verify_hi(prog_verify_hi), .erase_go_hi(erase_go_hi),
    .prog_go_hi(prog_go_hi), .erase_allow(erase_allow), .pe_protected(pe_protected),
    .overlay_active(overlay_active), .overlay_block(overlay_block), .probe_block(probe_block)
  );

  task give_verdict;
    $display("TB: checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // Request held from setup until pready is sampled high; one idle cycle between transfers
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t no pready", $time);
      give_verdict();
    end
  endtask : xfer

  task rd(input logic [11:0] a, input logic [31:0] e, input string m);
    xfer(1'b0, a, 32'h00000000);
    chk(rdat, e, m);
  endtask : rd

  // Write, read back, and compare the mode outputs that follow the control registers
  task wm(input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
    xfer(1'b1, a, d);
    rd(a, e, "readback");
    if (a == a_lo)
      chk({26'h0, lo_modes}, {26'h0, e[5:0]}, "lower modes");
    if (a == a_up)
      chk({26'h0, hi_modes}, {26'h0, e[5:0]}, "upper modes");
  endtask : wm

  initial
  begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    cyc(8);
    rd(a_lo, 32'h80, "lower reset");
    rd(a_up, 32'h00, "upper reset");
    rd(a_el, 32'h00, "eblk low reset");
    rd(a_eh, 32'h00, "eblk high reset");
    rd(a_ov, 32'h00, "overlay reset");
    chk({31'h0, pe_protected}, 32'h0, "unprotected");
    rd(12'h020, 32'h00, "unmapped data");
    chk({31'h0, rerr}, 32'h1, "unmapped err");
    // Each control write adds one new bit at most
    wm(a_lo, 32'h20, 32'h80);
    wm(a_lo, 32'h40, 32'hC0);
    wm(a_el, 32'hF1, 32'h01);
    chk({20'h0, erase_allow}, 32'h001, "allow blk0");
    wm(a_lo, 32'h60, 32'hE0);
    wm(a_lo, 32'h62, 32'hE2);
    wm(a_lo, 32'h60, 32'hE0);
    wm(a_lo, 32'h40, 32'hC0);
    wm(a_lo, 32'h42, 32'hC0);
    wm(a_lo, 32'h41, 32'hC0);
    wm(a_lo, 32'h50, 32'hD0);
    wm(a_lo, 32'h51, 32'hD1);
    wm(a_lo, 32'h40, 32'hC0);
    wm(a_lo, 32'h48, 32'hC8);
    wm(a_lo, 32'h40, 32'hC0);
    wm(a_lo, 32'h44, 32'hC4);
    wm(a_lo, 32'h40, 32'hC0);
    for (int i = 2; i < 6; i++)
    begin
      wm(a_up, 32'h1 << i, 32'h1 << i);
      wm(a_up, 32'h00, 32'h00);
    end
    wm(a_up, 32'h02, 32'h00);
    wm(a_up, 32'h20, 32'h20);
    wm(a_up, 32'h22, 32'h22);
    wm(a_up, 32'h01, 32'h00);
    wm(a_up, 32'h10, 32'h10);
    wm(a_up, 32'h11, 32'h11);
    wm(a_up, 32'h40, 32'h00);
    wm(a_eh, 32'h01, 32'h01);
    wm(a_lo, 32'h60, 32'hC0);
    wm(a_up, 32'h20, 32'h00);
    wm(a_el, 32'h00, 32'h00);
    wm(a_eh, 32'h80, 32'h80);
    chk({20'h0, erase_allow}, 32'h800, "allow blk11");
    // No emulated-area access is made right after an overlay change
    wm(a_ov, 32'hFFFFFFFF, 32'h07);
    chk({19'h0, overlay_active, overlay_block}, 32'h1800, "overlay on");
    chk({19'h0, pe_protected, erase_allow}, 32'h1000, "overlay protect");
    wm(a_up, 32'h10, 32'h10);
    wm(a_up, 32'h11, 32'h10);
    wm(a_up, 32'h00, 32'h00);
    for (int i = 0; i < 4; i++)
    begin
      wm(a_ov, 32'h4 + i, 32'h4 + i);
      chk({20'h0, overlay_block}, 32'h100 << i, "overlay area");
    end
    rom_disabled <= 1'b1;
    cyc(3);
    chk({31'h0, overlay_active}, 32'h0, "rom off");
    rom_disabled <= 1'b0;
    wm(a_ov, 32'h00, 32'h00);
    flash_disabled <= 1'b1;
    rd(a_eh, 32'h00, "disabled eblk");
    xfer(1'b1, a_eh, 32'h08);
    flash_disabled <= 1'b0;
    rd(a_eh, 32'h80, "write ignored");
    wm(a_up, 32'h10, 32'h10);
    op_failed <= 1'b1;
    cyc(1);
    op_failed <= 1'b0;
    rd(a_up, 32'h90, "error flag");
    chk({31'h0, pe_protected}, 32'h1, "error protect");
    wm(a_up, 32'h11, 32'h90);
    wm(a_ov, 32'h05, 32'h05);
    standby <= 1'b1;
    cyc(2);
    standby <= 1'b0;
    rd(a_lo, 32'h80, "lower standby");
    rd(a_up, 32'h80, "flag kept");
    rd(a_eh, 32'h00, "eblk standby");
    rd(a_ov, 32'h05, "overlay kept");
    wm(a_lo, 32'h40, 32'hC0);
    wm(a_eh, 32'h02, 32'h02);
    hw_protect_pin <= 1'b1;
    cyc(4);
    rd(a_lo, 32'h00, "pin high");
    rd(a_eh, 32'h00, "eblk pin high");
    rd(a_st, 32'h01, "status pin high");
    for (int i = 0; i < 7; i++)
    begin
      probe_addr <= pa[i];
      cyc(3);
      chk({20'h0, probe_block}, 32'h1 << pb[i], "probe decode");
    end
    give_verdict();
  end
endmodule : test_flash_program_erase_control

`default_nettype wire
